// File: src/osc_counter.v
// occlusion sample counter: query names, objects, depth pass counting
// ****************************************************************
// Functional notes
// [R01] begin clears count, sets active, records name
// [R02] end copies count, result unavailable, deactivates
// [R03] begin on unused name creates object
// [R04] begin errors: zero, already active, busy
// [R05] end without active query is error
// [R06] count only depth-passing fragments while active
// [R07] single sample mode adds one
// [R08] multisample adds covered sample count
// [R09] option: add samples per pixel if covered
// [R10] counter saturates at all ones
// [R11] allocate hands out unused names, no object
// [R12] new object result starts at zero
// [R13] name zero reserved, never handed out
// [R14] release deletes objects, ignores unused names
// [R15] allocate or release while active errors
// [R16] depth pass from compare or bypass
// [R17] commands and fragments handled in order
// ****************************************************************
`default_nettype none
`include "osc_defs.vh"
module osc_counter #(
   parameter NAME_W = 4,       // query name width
   parameter CNT_W = 32,       // samples-passed counter width
   parameter SAMPLES = 4,      // samples per pixel
   parameter DEPTH_W = 24,     // depth value width
   parameter WHOLE_PIXEL = 0   // 1 selects the whole-pixel add option
) (
   // clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // command stream
   input wire cmd_valid_i,
   input wire [2:0] cmd_op_i,
   input wire [NAME_W-1:0] cmd_name_i,
   // fragment stream from the depth stage
   input wire frag_valid_i,
   input wire [DEPTH_W-1:0] frag_z_i,
   input wire [DEPTH_W-1:0] stored_z_i,
   input wire [SAMPLES-1:0] frag_cover_i,
   // configuration
   input wire depth_test_en_i,
   input wire depth_buffer_present_i,
   input wire [2:0] depth_func_i,
   input wire multisample_buffer_count_i,
   // result readout, combinational lookup
   input wire [NAME_W-1:0] rd_name_i,
   output wire [CNT_W-1:0] rd_result_o,
   output wire rd_available_o,
   output wire rd_exists_o,
   // allocated name answer
   output reg alloc_valid_o,
   output reg [NAME_W-1:0] alloc_name_o,
   output reg alloc_fail_o,
   // status
   output reg query_active_o,
   output reg [NAME_W-1:0] active_name_o,
   output reg [CNT_W-1:0] sample_count_o,
   output reg depth_pass_o,
   output reg illegal_operation_error_o
);
   localparam NUM = 1 << NAME_W;
   localparam SC_W = $clog2(SAMPLES + 1);
   // samples per pixel held at adder width, so no bits are dropped silently
   localparam [SC_W-1:0] SAMPLES_N = SAMPLES;
   // per-name state
   reg [NUM-1:0] used;            // name marked used
   reg [NUM-1:0] exists;          // object created
   reg [NUM-1:0] avail;           // result available
   reg [CNT_W-1:0] result [0:NUM-1];
   // result available is never raised: readback completion is not modelled,
   // so a user must not wait on it
   // ****************************************************************
   // depth test
   // ****************************************************************
   // compare codes follow the depth_func_i encoding of the header
   reg cmp;
   always @* begin
      case (depth_func_i)
         `OSC_DF_NEVER: cmp = 1'b0;
         `OSC_DF_LESS: cmp = frag_z_i < stored_z_i;
         `OSC_DF_EQUAL: cmp = frag_z_i == stored_z_i;
         `OSC_DF_LEQUAL: cmp = frag_z_i <= stored_z_i;
         `OSC_DF_GREATER: cmp = frag_z_i > stored_z_i;
         `OSC_DF_NOTEQUAL: cmp = frag_z_i != stored_z_i;
         `OSC_DF_GEQUAL: cmp = frag_z_i >= stored_z_i;
         default: cmp = 1'b1;
      endcase
   end
   // bypass when disabled or absent
   wire pass = cmp | ~depth_test_en_i | ~depth_buffer_present_i; // [R16]
   // ****************************************************************
   // increment amount
   // ****************************************************************
   reg [SC_W-1:0] pop;
   integer k;
   // popcount of covered samples
   always @* begin
      pop = {SC_W{1'b0}};
      for (k = 0; k < SAMPLES; k = k + 1) begin
         pop = pop + {{(SC_W-1){1'b0}}, frag_cover_i[k]};
      end
   end
   reg [SC_W-1:0] inc;
   always @* begin
      if (!multisample_buffer_count_i) begin
         inc = {{(SC_W-1){1'b0}}, 1'b1}; // [R07]
      end else if (WHOLE_PIXEL != 0) begin
         inc = (|frag_cover_i) ? SAMPLES_N : {SC_W{1'b0}}; // [R09]
      end else begin
         inc = pop; // [R08]
      end
   end
   // saturating sum; wider by one bit to see the overflow
   wire [CNT_W:0] sum = {1'b0, sample_count_o} + {{(CNT_W+1-SC_W){1'b0}}, inc};
   wire [CNT_W-1:0] sat = sum[CNT_W] ? {CNT_W{1'b1}} : sum[CNT_W-1:0]; // [R10]
   // ****************************************************************
   // free name search, lowest nonzero unused name
   // ****************************************************************
   reg [NAME_W-1:0] free_name;
   reg free_found;
   integer j;
   always @* begin
      free_name = `OSC_NAME_NONE;
      free_found = 1'b0;
      // stop at one so zero is never offered
      for (j = NUM - 1; j >= 1; j = j - 1) begin
         if (!used[j]) begin
            free_name = j[NAME_W-1:0]; // [R13]
            free_found = 1'b1;
         end
      end
   end
   // ****************************************************************
   // command decode
   // ****************************************************************
   // one command per cycle, decoded once and shared by all entries
   wire is_begin = cmd_valid_i && (cmd_op_i == `OSC_OP_BEGIN);
   wire is_end = cmd_valid_i && (cmd_op_i == `OSC_OP_END);
   wire is_alloc = cmd_valid_i && (cmd_op_i == `OSC_OP_ALLOC);
   wire is_rel = cmd_valid_i && (cmd_op_i == `OSC_OP_RELEASE);
   // only one target exists, so "same target" and "any" coincide
   wire begin_bad = (cmd_name_i == `OSC_NAME_NONE) || query_active_o; // [R04]
   wire begin_ok = is_begin && !begin_bad;
   wire end_bad = is_end && !query_active_o; // [R05]
   wire mgmt_bad = (is_alloc || is_rel) && query_active_o; // [R15]
   // ****************************************************************
   // per-name state, one generate entry per name
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < NUM; g = g + 1) begin : g_obj
         always @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               used[g] <= 1'b0;
               exists[g] <= 1'b0;
               avail[g] <= 1'b0;
               result[g] <= {CNT_W{1'b0}};
            end else if (begin_ok && cmd_name_i == g) begin
               used[g] <= 1'b1; // [R03]
               if (!exists[g]) begin
                  exists[g] <= 1'b1; // [R03]
                  result[g] <= {CNT_W{1'b0}}; // [R12]
                  avail[g] <= 1'b0;
               end
            end else if (is_end && query_active_o && active_name_o == g) begin
               // a fragment in this same cycle still lands in the copy
               result[g] <= (frag_valid_i && pass) ? sat : sample_count_o; // [R02] [R17]
               avail[g] <= 1'b0; // [R02]
            end else if (is_alloc && !query_active_o && free_found && free_name == g) begin
               used[g] <= 1'b1; // [R11]
            end else if (is_rel && !query_active_o && cmd_name_i == g && g != 0) begin
               // unused names fall through untouched
               used[g] <= 1'b0; // [R14]
               exists[g] <= 1'b0; // [R14]
               result[g] <= {CNT_W{1'b0}};
            end
         end
      end
   endgenerate
   // readout is a plain mux over the state registers
   assign rd_result_o = result[rd_name_i];
   assign rd_available_o = avail[rd_name_i];
   assign rd_exists_o = exists[rd_name_i];
   // ****************************************************************
   // active query, counter, answers
   // ****************************************************************
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         query_active_o <= 1'b0;
         active_name_o <= `OSC_NAME_NONE;
         sample_count_o <= {CNT_W{1'b0}};
         depth_pass_o <= 1'b0;
         illegal_operation_error_o <= 1'b0;
         alloc_valid_o <= 1'b0;
         alloc_name_o <= `OSC_NAME_NONE;
         alloc_fail_o <= 1'b0;
      end else begin
         depth_pass_o <= frag_valid_i && pass;
         illegal_operation_error_o <= (is_begin && begin_bad) || end_bad || mgmt_bad;
         // no answer is raised on an empty pool, so zero is never offered
         alloc_valid_o <= is_alloc && !query_active_o && free_found; // [R13]
         alloc_name_o <= (is_alloc && !query_active_o) ? free_name : `OSC_NAME_NONE;
         alloc_fail_o <= is_alloc && !query_active_o && !free_found;
         if (begin_ok) begin
            // fragment in the begin cycle belongs before the begin
            query_active_o <= 1'b1; // [R01]
            active_name_o <= cmd_name_i; // [R01]
            sample_count_o <= {CNT_W{1'b0}}; // [R01] [R17]
         end else if (is_end && query_active_o) begin
            query_active_o <= 1'b0; // [R02]
            active_name_o <= `OSC_NAME_NONE; // [R02]
            // keep the live count in step with the copied result
            if (frag_valid_i && pass) begin
               sample_count_o <= sat; // [R17]
            end
         end else if (query_active_o && frag_valid_i && pass) begin
            sample_count_o <= sat; // [R06]
         end
      end
   end
endmodule
`default_nettype wire

// File: src/osc_defs.vh
// constants for the occlusion sample counter
`ifndef OSC_DEFS_VH
`define OSC_DEFS_VH
// command opcodes on cmd_op_i
`define OSC_OP_BEGIN 3'h1
`define OSC_OP_END 3'h2
`define OSC_OP_ALLOC 3'h3
`define OSC_OP_RELEASE 3'h4
// depth compare functions on depth_func_i
`define OSC_DF_NEVER 3'h0
`define OSC_DF_LESS 3'h1
`define OSC_DF_EQUAL 3'h2
`define OSC_DF_LEQUAL 3'h3
`define OSC_DF_GREATER 3'h4
`define OSC_DF_NOTEQUAL 3'h5
`define OSC_DF_GEQUAL 3'h6
`define OSC_DF_ALWAYS 3'h7
// reserved query name
`define OSC_NAME_NONE 4'h0
`endif

// File: testbench/osc_counter_props.sv
// port checks for the occlusion sample counter
`default_nettype none
`include "osc_defs.vh"
module osc_counter_props #(parameter int CNT_W = 32) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // inputs
   input wire logic cmd_valid_i,
   input wire logic [2:0] cmd_op_i,
   input wire logic [3:0] cmd_name_i,
   input wire logic frag_valid_i,
   input wire logic depth_test_en_i,
   input wire logic depth_buffer_present_i,
   input wire logic multisample_buffer_count_i,
   // outputs
   input wire logic alloc_valid_o,
   input wire logic [3:0] alloc_name_o,
   input wire logic query_active_o,
   input wire logic [3:0] active_name_o,
   input wire logic [CNT_W-1:0] sample_count_o,
   input wire logic depth_pass_o,
   input wire logic illegal_operation_error_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // decoded commands
   // ****
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire beg = cmd_valid_i && cmd_op_i == `OSC_OP_BEGIN;
   wire fin = cmd_valid_i && cmd_op_i == `OSC_OP_END;
   wire alc = cmd_valid_i && cmd_op_i == `OSC_OP_ALLOC;
   wire pool = alc || (cmd_valid_i && cmd_op_i == `OSC_OP_RELEASE);
   wire top = &sample_count_o; // saturated value
   sequence s_start;
      beg && cmd_name_i != 0 && !query_active_o;
   endsequence
   sequence s_stop;
      fin && query_active_o;
   endsequence
   AST_BEGIN: assert property (s_start |=> query_active_o && sample_count_o == 0
      && active_name_o == $past(cmd_name_i)) else $error("begin not taken");
   AST_END: assert property (s_stop |=> !query_active_o && active_name_o == 0)
      else $error("end not taken");
   AST_BAD_BEGIN: assert property (beg && (cmd_name_i == 0 || query_active_o)
      |=> illegal_operation_error_o && $stable(active_name_o)) else $error("bad begin");
   AST_BAD_END: assert property (fin && !query_active_o |=> illegal_operation_error_o)
      else $error("bad end");
   AST_POOL: assert property (pool && query_active_o |=> illegal_operation_error_o
      && !alloc_valid_o) else $error("pool change while active");
   AST_IDLE: assert property (!query_active_o && !beg |=> $stable(sample_count_o))
      else $error("count moved while idle");
   AST_ONE: assert property (query_active_o && frag_valid_i && !beg && !top
      && !multisample_buffer_count_i |=> sample_count_o == $past(sample_count_o)
      + depth_pass_o) else $error("single sample add wrong");
   AST_SAT: assert property (query_active_o && !beg && top |=> top)
      else $error("count wrapped");
   AST_BYPASS: assert property (frag_valid_i && (!depth_test_en_i
      || !depth_buffer_present_i) |=> depth_pass_o) else $error("bypass failed");
   AST_NAME: assert property (alloc_valid_o |-> alloc_name_o != 0 && $past(alc))
      else $error("bad allocation");
endmodule
`default_nettype wire

// File: testbench/osc_frag_src.sv
// fragment source standing in for the depth stage
`default_nettype none
module osc_frag_src (
   // request from the bench
   input wire logic req_i,
   input wire logic [23:0] z_i,
   input wire logic [23:0] sz_i,
   input wire logic [3:0] cov_i,
   // fragment towards the counter
   output logic frag_valid_o,
   output logic [23:0] frag_z_o,
   output logic [23:0] stored_z_o,
   output logic [3:0] frag_cover_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // one fragment per request, in bench order
   assign frag_valid_o = req_i;
   // idle lines inverted so stale data never looks valid
   assign frag_z_o = req_i ? z_i : ~z_i;
   assign stored_z_o = req_i ? sz_i : ~sz_i;
   assign frag_cover_o = req_i ? cov_i : ~cov_i;
endmodule
`default_nettype wire

// File: testbench/occlusion_sample_counter_tb_top.sv
// self-checking bench for the occlusion sample counter
`default_nettype none
`include "osc_defs.vh"
module occlusion_sample_counter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // stimulus and observed signals
   // ****
   logic clk_i = 0, rst_n_i = 0, cv = 0, req = 0, ten = 1, dbp = 1, msb = 0;
   logic [2:0] op = 0, df = `OSC_DF_LESS;
   logic [3:0] nm = 0, rn = 0, cov = 0;
   logic [23:0] z = 0, sz = 24'h2; // stored depth fixed at 2
   wire fv, act, dp, err, avl, av, ex, fl;
   wire [3:0] cnt_wp; // count of the whole-pixel counter
   wire [23:0] fz, fsz;
   wire [3:0] fc, an, aln, cnt, res;
   int mismatches = 0, check_count = 0;
   initial forever #2 clk_i = ~clk_i;
   // small counter so saturation is reachable
   osc_counter #(.CNT_W(4)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cv),
      .cmd_op_i(op), .cmd_name_i(nm), .frag_valid_i(fv), .frag_z_i(fz), .stored_z_i(fsz),
      .frag_cover_i(fc), .depth_test_en_i(ten), .depth_buffer_present_i(dbp),
      .depth_func_i(df), .multisample_buffer_count_i(msb), .rd_name_i(rn),
      .rd_result_o(res), .rd_available_o(av), .rd_exists_o(ex), .alloc_valid_o(avl),
      .alloc_name_o(aln), .alloc_fail_o(fl), .query_active_o(act), .active_name_o(an),
      .sample_count_o(cnt), .depth_pass_o(dp), .illegal_operation_error_o(err));
   osc_frag_src src (.req_i(req), .z_i(z), .sz_i(sz), .cov_i(cov), .frag_valid_o(fv),
      .frag_z_o(fz), .stored_z_o(fsz), .frag_cover_o(fc));
   // second counter with the whole-pixel add option, same stimulus
   osc_counter #(.CNT_W(4), .WHOLE_PIXEL(1)) dut_wp (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .cmd_valid_i(cv), .cmd_op_i(op), .cmd_name_i(nm), .frag_valid_i(fv), .frag_z_i(fz),
      .stored_z_i(fsz), .frag_cover_i(fc), .depth_test_en_i(ten),
      .depth_buffer_present_i(dbp), .depth_func_i(df), .multisample_buffer_count_i(msb),
      .rd_name_i(rn), .rd_result_o(), .rd_available_o(), .rd_exists_o(), .alloc_valid_o(),
      .alloc_name_o(), .alloc_fail_o(), .query_active_o(), .active_name_o(),
      .sample_count_o(cnt_wp), .depth_pass_o(), .illegal_operation_error_o());
   // one cycle of command and fragment, result settled on return
   task automatic go(input logic c, input logic [2:0] o, input logic [3:0] n,
      input logic f, input logic [23:0] zv, input logic [3:0] cv4);
      @(negedge clk_i);
      cv = c;
      op = o;
      nm = n;
      req = f;
      z = zv;
      cov = cv4;
      @(negedge clk_i);
      cv = 0;
      req = 0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      #20000;
      mismatches++;
      complete_run;
   end
   initial begin
      repeat (6) @(negedge clk_i);
      rst_n_i = 1;
      chk({act, cnt}, 0);
      // every compare function, z 1 against stored 2
      for (int i = 0; i < 8; i++) begin
         df = i[2:0];
         go(0, 0, 0, 1, 1, 0);
         chk(dp, (8'haa >> i) & 1);
      end
      $display("depth compare test done");
      df = `OSC_DF_LESS;
      go(1, `OSC_OP_ALLOC, 0, 0, 0, 0);
      chk({avl, aln}, 5'h11);
      go(1, `OSC_OP_ALLOC, 0, 0, 0, 0);
      chk({avl, aln}, 5'h12);
      rn = 1;
      go(1, `OSC_OP_BEGIN, 1, 1, 1, 0);
      chk({act, an, cnt, ex, res}, 14'h2210);
      go(0, 0, 0, 1, 1, 0);
      chk({dp, cnt}, 5'h11);
      go(0, 0, 0, 1, 3, 0);
      chk({dp, cnt}, 5'h01);
      ten = 0;
      go(0, 0, 0, 1, 3, 0);
      chk(cnt, 2);
      msb = 1;
      go(0, 0, 0, 1, 3, 4'hb);
      chk(cnt, 5);
      chk(cnt_wp, 6);
      $display("counting test done");
      go(1, `OSC_OP_BEGIN, 2, 0, 0, 0);
      chk({err, an}, 5'h11);
      go(1, `OSC_OP_ALLOC, 0, 0, 0, 0);
      chk({err, avl}, 2'h2);
      go(1, `OSC_OP_END, 0, 1, 3, 4'h1);
      chk({act, an, res, av}, 10'h00c);
      go(1, `OSC_OP_END, 0, 0, 0, 0);
      chk(err, 1);
      go(1, `OSC_OP_BEGIN, 0, 0, 0, 0);
      chk({err, act}, 2'h2);
      $display("error test done");
      ten = 1;
      dbp = 0;
      rn = 2;
      go(1, `OSC_OP_BEGIN, 2, 0, 0, 0);
      repeat (4) go(0, 0, 0, 1, 3, 4'hf);
      chk({cnt, cnt_wp}, 8'hff);
      go(1, `OSC_OP_END, 0, 0, 0, 0);
      chk({res, av}, 5'h1e);
      $display("saturation test done");
      rn = 1;
      go(1, `OSC_OP_RELEASE, 1, 0, 0, 0);
      chk({err, ex}, 0);
      go(1, `OSC_OP_RELEASE, 9, 0, 0, 0);
      chk(err, 0);
      go(1, `OSC_OP_ALLOC, 0, 0, 0, 0);
      chk({avl, aln}, 5'h11);
      rn = 5;
      go(1, `OSC_OP_BEGIN, 5, 0, 0, 0);
      chk({ex, res}, 5'h10);
      $display("name pool test done");
      // names 1, 2 and 5 are used: twelve left, the last being 15
      go(1, `OSC_OP_END, 0, 0, 0, 0);
      chk(act, 0);
      repeat (12) go(1, `OSC_OP_ALLOC, 0, 0, 0, 0);
      chk({avl, aln}, 5'h1f);
      go(1, `OSC_OP_ALLOC, 0, 0, 0, 0);
      chk({fl, avl, aln}, 6'h20);
      $display("pool exhaustion test done");
      complete_run;
   end
endmodule
bind osc_counter osc_counter_props #(.CNT_W(CNT_W)) props (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_name_i(cmd_name_i),
   .frag_valid_i(frag_valid_i), .depth_test_en_i(depth_test_en_i),
   .depth_buffer_present_i(depth_buffer_present_i),
   .multisample_buffer_count_i(multisample_buffer_count_i), .alloc_valid_o(alloc_valid_o),
   .alloc_name_o(alloc_name_o), .query_active_o(query_active_o),
   .active_name_o(active_name_o), .sample_count_o(sample_count_o),
   .depth_pass_o(depth_pass_o), .illegal_operation_error_o(illegal_operation_error_o));
`default_nettype wire
